// ---- icache_pkg.sv ----
// Shared constants and types for the instruction cache block
package icache_pkg;

  localparam int WORD_W      = 32;
  localparam int LINE_WORDS  = 4;
  localparam int LINE_BYTES  = 16;
  localparam int WAYS        = 2;
  localparam int KBYTES_FULL = 4;
  localparam int KBYTES_SMALL = 2;
  localparam int LINE_ADDR_W = 28;
  localparam int DUMP_SLOTS  = 6;
  localparam int CFG_DISABLE_BIT = 16;
  localparam int CMD_MODE_LSB    = 4;

  localparam logic [7:0] OFF_CONFIG    = 8'h00;
  localparam logic [7:0] OFF_COMMAND   = 8'h04;
  localparam logic [7:0] OFF_LOCK_ADDR = 8'h08;
  localparam logic [7:0] OFF_DUMP_ADDR = 8'h0c;
  localparam logic [7:0] OFF_STATUS    = 8'h10;

  localparam logic [31:0] RST_CONFIG    = 32'h0000_0000;
  localparam logic [31:0] RST_LOCK_ADDR = 32'h0000_0000;
  localparam logic [31:0] RST_DUMP_ADDR = 32'h0000_0000;

  localparam logic [2:0] BURST_QUAD = 3'h4;
  localparam logic [2:0] BURST_PAIR = 3'h2;
  localparam logic [2:0] BURST_ONE  = 3'h1;

  localparam int ST_ENABLED_BIT = 0;
  localparam int ST_LOCKED_BIT  = 1;
  localparam int ST_BUSY_BIT    = 2;
  localparam int ST_SMALL_BIT   = 3;

  typedef enum logic [2:0] {
    OP_NONE, OP_ENABLE, OP_DISABLE, OP_INVALIDATE, OP_STORE, OP_CONFIGURE, OP_REINIT
  } cache_op_t;

  typedef enum logic [1:0] {
    MODE_DISABLE, MODE_ENABLE, MODE_LOAD_LOCK, MODE_INVALIDATE
  } cfg_mode_t;

  typedef struct packed {
    logic      valid;
    cache_op_t op;
    cfg_mode_t mode;
  } cache_cmd_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [2:0]  burst;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic         done;
    logic [3:0]   valid;
    logic [127:0] words;
  } fetch_rsp_t;
endpackage : icache_pkg

// ---- icache_regs.sv ----
// APB register slave for the instruction cache controls
`timescale 1ns/1ps
module icache_regs import icache_pkg::*; (
  input  wire logic        ref_clk,     // Clock
  input  wire logic        reset,       // Sync reset
  input  wire logic [31:0] paddr,       // APB address
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [31:0] pwdata,      // APB write data
  output logic      [31:0] prdata,      // APB read data
  output logic             pready,      // APB ready
  output logic             pslverr,     // APB error
  input  wire logic [31:0] status,      // Live status word
  output cache_cmd_t       cmd,         // Command pulse
  output logic      [31:0] config_word, // Cache configuration word
  output logic      [31:0] lock_addr,   // Lock start address
  output logic      [31:0] dump_addr    // Dump target address
);
  wire logic setup   = psel & ~penable;
  wire logic access  = psel & penable;
  wire logic hi_zero = (paddr[31:8] == 24'h0);
  wire logic sel_cfg = hi_zero & (paddr[7:0] == OFF_CONFIG);
  wire logic sel_cmd = hi_zero & (paddr[7:0] == OFF_COMMAND);
  wire logic sel_lck = hi_zero & (paddr[7:0] == OFF_LOCK_ADDR);
  wire logic sel_dmp = hi_zero & (paddr[7:0] == OFF_DUMP_ADDR);
  wire logic sel_sts = hi_zero & (paddr[7:0] == OFF_STATUS);
  wire logic mapped  = sel_cfg | sel_cmd | sel_lck | sel_dmp | sel_sts;
  wire logic wr      = access & pwrite;
  // Status is sampled in the setup cycle: that read is the status query
  wire logic [31:0] rd_word = sel_cfg ? config_word :
                              sel_lck ? lock_addr :
                              sel_dmp ? dump_addr :
                              sel_sts ? status : 32'h0000_0000;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      config_word <= RST_CONFIG;
      lock_addr   <= RST_LOCK_ADDR;
      dump_addr   <= RST_DUMP_ADDR;
      cmd         <= '0;
      prdata      <= 32'h0000_0000;
    end else begin
      cmd.valid <= wr & sel_cmd;
      cmd.op    <= cache_op_t'(pwdata[2:0]);
      cmd.mode  <= cfg_mode_t'(pwdata[CMD_MODE_LSB +: 2]);
      if (wr & sel_cfg) config_word <= pwdata;
      if (wr & sel_lck) lock_addr <= pwdata;
      if (wr & sel_dmp) dump_addr <= pwdata;
      if (setup) prdata <= rd_word;
    end
  end
endmodule : icache_regs

// ---- fetch_buffer.sv ----
// Single-tag four-word instruction fetch buffer
`timescale 1ns/1ps
module fetch_buffer import icache_pkg::*; (
  input  wire logic                   ref_clk,    // Clock
  input  wire logic                   reset,      // Sync reset
  input  wire logic                   clear_all,  // Drop every valid bit
  input  wire logic                   clear_load, // Miss: clear and take new tag
  input  wire logic                   bulk_load,  // Load a whole line from the cache
  input  wire logic [LINE_ADDR_W-1:0] new_tag,    // Tag for clear_load or bulk_load
  input  wire logic [127:0]           bulk_words, // Line words for bulk_load
  input  wire logic [3:0]             bulk_mask,  // Word valid bits for bulk_load
  input  wire logic                   wr_en,      // Refill word write
  input  wire logic [1:0]             wr_word,    // Refill word index
  input  wire logic [WORD_W-1:0]      wr_data,    // Refill word
  input  wire logic [LINE_ADDR_W-1:0] look_line,  // Lookup line address
  input  wire logic [1:0]             look_word,  // Lookup word index
  output logic                        hit,        // Lookup hit
  output logic      [127:0]           words,      // Buffered words
  output logic      [3:0]             valid       // Word valid bits
);
  logic [LINE_ADDR_W-1:0] tag;

  assign hit = (tag == look_line) & valid[look_word];

  always_ff @(posedge ref_clk) begin
    if (reset || clear_all) begin
      valid <= 4'h0;
      tag   <= '0;
      words <= '0;
    end else if (clear_load) begin
      valid <= 4'h0;
      tag   <= new_tag;
    end else if (bulk_load) begin
      valid <= bulk_mask;
      tag   <= new_tag;
      words <= bulk_words;
    end else if (wr_en) begin
      valid[wr_word]            <= 1'b1;
      words[wr_word*WORD_W +: WORD_W] <= wr_data;
    end
  end
endmodule : fetch_buffer

// ---- instruction_cache_with_fetch_buffer.sv ----
// Two-way instruction cache with fetch buffer, lock, dump and APB control
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module instruction_cache_with_fetch_buffer import icache_pkg::*; #(
  parameter int CACHE_KBYTES = KBYTES_FULL
) (
  input  wire logic        ref_clk,    // 100 MHz clock
  input  wire logic        reset,      // Sync reset, active high
  input  wire logic [31:0] paddr,      // APB address
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  input  wire logic        fetch_req,  // Fetch request, held until ready
  input  wire logic [31:0] fetch_addr, // Instruction pointer of request
  output logic             fetch_ready,// Request accepted this cycle
  output fetch_rsp_t       fetch_rsp,  // Answer, one cycle after ready
  output mem_req_t         mem_out,    // External memory request
  input  wire logic        mem_ack,    // One word done
  input  wire logic [31:0] mem_rdata   // Read word, valid with mem_ack
);
  localparam int SETS   = CACHE_KBYTES * 1024 / (WAYS * LINE_BYTES);
  localparam int IDX_W  = $clog2(SETS);
  localparam int XFER_W = 12;
  localparam logic [XFER_W-1:0] LOCK_WORDS = XFER_W'(SETS * LINE_WORDS);
  localparam logic [XFER_W-1:0] DUMP_WORDS = XFER_W'(WAYS * SETS * DUMP_SLOTS);
  localparam logic [2:0] LAST_SLOT = 3'(DUMP_SLOTS - 1);

  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_LOCK, ST_DUMP} state_t;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [WORD_W-1:0]      line_data [WAYS][SETS][LINE_WORDS];
  logic [LINE_ADDR_W-1:0] line_tag  [WAYS][SETS];
  logic [3:0]             word_ok   [WAYS][SETS];
  logic                   victim    [SETS];

  state_t            st;
  logic              enabled;
  logic              locked;
  logic              fill_way;
  logic              fill_cache;
  logic [2:0]        burst;
  logic [31:0]       xfer_addr;
  logic [XFER_W-1:0] xfer_left;
  logic [2:0]        d_slot;
  logic [IDX_W:0]    d_line;

  cache_cmd_t  cmd;
  logic [31:0] config_word;
  logic [31:0] lock_addr;
  logic [31:0] dump_addr;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  icache_regs u_regs (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .paddr       (paddr),
    .psel        (psel),
    .penable     (penable),
    .pwrite      (pwrite),
    .pwdata      (pwdata),
    .prdata      (prdata),
    .pready      (pready),
    .pslverr     (pslverr),
    .status      (status),
    .cmd         (cmd),
    .config_word (config_word),
    .lock_addr   (lock_addr),
    .dump_addr   (dump_addr)
  );

  always_comb begin
    status                 = 32'h0000_0000;
    status[ST_ENABLED_BIT] = enabled;
    status[ST_LOCKED_BIT]  = locked;
    status[ST_BUSY_BIT]    = (st != ST_IDLE);
    status[ST_SMALL_BIT]   = (CACHE_KBYTES == KBYTES_SMALL);
  end

  // ----------------------------------------------------------------
  // Lookup
  // ----------------------------------------------------------------
  wire logic [LINE_ADDR_W-1:0] req_line = fetch_addr[31:4];
  wire logic [1:0]             req_word = fetch_addr[3:2];
  wire logic [IDX_W-1:0]       req_idx  = req_line[IDX_W-1:0];
  wire logic idle = (st == ST_IDLE);

  // Both ways answer hits even while one is locked
  wire logic hit0 = enabled & (line_tag[0][req_idx] == req_line)
                    & word_ok[0][req_idx][req_word];
  wire logic hit1 = enabled & (line_tag[1][req_idx] == req_line)
                    & word_ok[1][req_idx][req_word];
  wire logic cache_hit = hit0 | hit1;
  wire logic hit_way   = hit1;

  logic [127:0] hit_words;
  for (genvar g = 0; g < LINE_WORDS; g++) begin : g_hit_words
    assign hit_words[g*WORD_W +: WORD_W] = line_data[hit_way][req_idx][g];
  end
  wire logic [3:0] hit_mask = word_ok[hit_way][req_idx];

  logic         buf_hit;
  logic [127:0] buf_words;
  logic [3:0]   buf_valid;

  // Commands win over a new miss so a fill never races a reconfiguration
  wire logic cmd_go     = idle & cmd.valid;
  wire logic miss_start = idle & fetch_req & ~buf_hit & ~cache_hit & ~cmd_go;
  wire logic miss_way   = locked | (line_tag[1][req_idx] == req_line)
                          | ((line_tag[0][req_idx] != req_line) & victim[req_idx]);
  wire logic miss_quad  = (req_word < 2'h2);

  assign fetch_ready = idle & fetch_req & (buf_hit | cache_hit);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire logic is_cfg     = cmd_go & (cmd.op == OP_CONFIGURE);
  wire logic do_enable  = (cmd_go & (cmd.op == OP_ENABLE))
                          | (is_cfg & (cmd.mode == MODE_ENABLE));
  wire logic do_disable = (cmd_go & (cmd.op == OP_DISABLE))
                          | (is_cfg & (cmd.mode == MODE_DISABLE));
  wire logic do_reinit  = cmd_go & (cmd.op == OP_REINIT);
  wire logic do_lock    = is_cfg & (cmd.mode == MODE_LOAD_LOCK);
  wire logic do_store   = cmd_go & (cmd.op == OP_STORE);
  // Three separate commands reach the same invalidate
  wire logic do_inval   = (cmd_go & (cmd.op == OP_INVALIDATE))
                          | (is_cfg & (cmd.mode == MODE_INVALIDATE))
                          | do_reinit;

  // ----------------------------------------------------------------
  // Array write port
  // ----------------------------------------------------------------
  wire logic [LINE_ADDR_W-1:0] xfer_line = xfer_addr[31:4];
  wire logic [1:0]             xfer_word = xfer_addr[3:2];
  wire logic fill_ack = (st == ST_FILL) & mem_ack;
  wire logic lock_wr  = (st == ST_LOCK) & mem_ack;
  // A fill into a disabled cache only feeds the buffer
  wire logic fill_wr  = fill_ack & fill_cache;
  wire logic wr_en    = fill_wr | lock_wr;
  wire logic wr_way   = lock_wr ? 1'b0 : fill_way;
  wire logic [IDX_W-1:0] wr_idx = xfer_line[IDX_W-1:0];
  wire logic miss_tag = miss_start & enabled
                        & (line_tag[miss_way][req_idx] != req_line);
  wire logic tag_set  = miss_tag | (lock_wr & (xfer_word == 2'h0));
  wire logic tag_way  = lock_wr ? 1'b0 : miss_way;
  wire logic [IDX_W-1:0] tag_idx = lock_wr ? wr_idx : req_idx;
  wire logic [LINE_ADDR_W-1:0] tag_line = lock_wr ? xfer_line : req_line;

  always_ff @(posedge ref_clk) begin
    if (reset || do_inval) begin
      for (int w = 0; w < WAYS; w++) begin
        for (int s = 0; s < SETS; s++) begin
          word_ok[w][s] <= 4'h0;
          line_tag[w][s] <= '0;
        end
      end
    end else if (do_lock) begin
      for (int s = 0; s < SETS; s++) begin
        word_ok[0][s] <= 4'h0;
      end
    end else begin
      if (tag_set) begin
        line_tag[tag_way][tag_idx] <= tag_line;
        word_ok[tag_way][tag_idx]  <= 4'h0;
      end
      if (wr_en) begin
        line_data[wr_way][wr_idx][xfer_word] <= mem_rdata;
        word_ok[wr_way][wr_idx][xfer_word]   <= 1'b1;
      end
    end
  end

  // Victim points at the way not used last
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      for (int s = 0; s < SETS; s++) begin
        victim[s] <= 1'b0;
      end
    end else if (fetch_ready & ~buf_hit) begin
      victim[req_idx] <= ~hit_way;
    end else if (miss_start) begin
      victim[req_idx] <= ~miss_way;
    end
  end

  // ----------------------------------------------------------------
  // Fetch buffer
  // ----------------------------------------------------------------
  fetch_buffer u_buf (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .clear_all  (do_inval),
    .clear_load (miss_start),
    .bulk_load  (fetch_ready & ~buf_hit),
    .new_tag    (req_line),
    .bulk_words (hit_words),
    .bulk_mask  (hit_mask),
    .wr_en      (fill_ack),
    .wr_word    (xfer_word),
    .wr_data    (mem_rdata),
    .look_line  (req_line),
    .look_word  (req_word),
    .hit        (buf_hit),
    .words      (buf_words),
    .valid      (buf_valid)
  );

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  wire logic last_word = mem_ack & (xfer_left == XFER_W'(1));
  wire logic d_way = d_line[IDX_W];
  wire logic [IDX_W-1:0] d_set = d_line[IDX_W-1:0];

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st         <= ST_IDLE;
      enabled    <= ~RST_CONFIG[CFG_DISABLE_BIT];
      locked     <= 1'b0;
      fill_way   <= 1'b0;
      fill_cache <= 1'b0;
      burst      <= 3'h0;
      xfer_addr  <= 32'h0000_0000;
      xfer_left  <= '0;
      d_slot     <= 3'h0;
      d_line     <= '0;
    end else begin
      case (st)
        ST_IDLE: begin
          if (do_reinit) begin
            enabled <= ~config_word[CFG_DISABLE_BIT];
          end else if (do_enable) begin
            enabled <= 1'b1;
          end else if (do_disable) begin
            enabled <= 1'b0;
          end
          if (do_inval) locked <= 1'b0;
          if (do_lock) begin
            st        <= ST_LOCK;
            locked    <= 1'b0;
            burst     <= BURST_QUAD;
            xfer_addr <= {lock_addr[31:4], 4'h0};
            xfer_left <= LOCK_WORDS;
          end else if (do_store) begin
            st        <= ST_DUMP;
            burst     <= BURST_ONE;
            xfer_addr <= {dump_addr[31:2], 2'h0};
            xfer_left <= DUMP_WORDS;
            d_slot    <= 3'h0;
            d_line    <= '0;
          end else if (miss_start) begin
            st         <= ST_FILL;
            fill_way   <= miss_way;
            fill_cache <= enabled;
            burst      <= miss_quad ? BURST_QUAD : BURST_PAIR;
            xfer_addr  <= {req_line, miss_quad ? 2'h0 : 2'h2, 2'h0};
            xfer_left  <= miss_quad ? XFER_W'(4) : XFER_W'(2);
          end
        end
        ST_FILL, ST_LOCK, ST_DUMP: begin
          if (mem_ack) begin
            xfer_addr <= xfer_addr + 32'h0000_0004;
            xfer_left <= xfer_left - XFER_W'(1);
            d_slot    <= (d_slot == LAST_SLOT) ? 3'h0 : d_slot + 3'h1;
            if (d_slot == LAST_SLOT) d_line <= d_line + 1'b1;
          end
          if (last_word) begin
            st <= ST_IDLE;
            if (st == ST_LOCK) begin
              locked  <= 1'b1;
              enabled <= 1'b1;
            end
          end
        end
        default: st <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [31:0] dump_word;
  always_comb begin
    if (d_slot < 3'h4) begin
      dump_word = line_data[d_way][d_set][d_slot[1:0]];
    end else if (d_slot == 3'h4) begin
      dump_word = {4'h0, line_tag[d_way][d_set]};
    end else begin
      dump_word = {28'h0, word_ok[d_way][d_set]};
    end
  end

  // Reads and writes of program memory are never watched here; no snoop port
  assign mem_out.req   = ~idle;
  assign mem_out.we    = (st == ST_DUMP);
  assign mem_out.burst = burst;
  assign mem_out.addr  = xfer_addr;
  assign mem_out.wdata = (st == ST_DUMP) ? dump_word : 32'h0000_0000;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fetch_rsp <= '0;
    end else begin
      fetch_rsp.done <= fetch_ready;
      if (fetch_ready) begin
        fetch_rsp.words <= buf_hit ? buf_words : hit_words;
        fetch_rsp.valid <= buf_hit ? buf_valid : hit_mask;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_hit_one_cycle: assert property (fetch_ready |=> fetch_rsp.done)
    else $error("hit not answered next cycle");
  a_quad_miss_fetch: assert property (miss_start && req_word < 2'h2 |=>
    mem_out.req && mem_out.burst == 3'h4 && mem_out.addr[3:2] == 2'h0)
    else $error("quad fetch wrong");
  a_pair_miss_fetch: assert property (miss_start && req_word >= 2'h2 |=>
    mem_out.req && mem_out.burst == 3'h2 && mem_out.addr[3:2] == 2'h2)
    else $error("pair fetch wrong");
  a_disabled_no_hit: assert property (!enabled |-> !cache_hit && !fill_wr)
    else $error("disabled cache used");
  a_disable_holds: assert property (!enabled && idle && !cmd.valid |=> !enabled)
    else $error("cache left disable by itself");
  a_buffer_clears: assert property (miss_start |=> buf_valid == 4'h0)
    else $error("buffer not cleared on miss");
  a_buffer_quiet: assert property (idle && fetch_req && buf_hit |=> !mem_out.req)
    else $error("external fetch on buffer hit");
  a_locked_way_kept: assert property (locked && wr_en |-> wr_way == 1'b1)
    else $error("locked way replaced");
  a_lock_way_fill: assert property (do_lock |=> st == ST_LOCK && !locked
    && mem_out.addr == {$past(lock_addr[31:4]), 4'h0})
    else $error("lock fill start wrong");
  a_dump_writes: assert property (st == ST_DUMP |-> mem_out.we)
    else $error("dump not writing");

  c_buffer_hit: cover property (fetch_ready && buf_hit);
  c_miss_fill: cover property (miss_start ##[1:20] st == ST_IDLE);
  c_lock_done: cover property (st == ST_LOCK ##1 locked);
  c_locked_miss: cover property (locked && miss_start);
endmodule : instruction_cache_with_fetch_buffer

// ---- icache_mem_model.sv ----
// External memory model answering cache fills and dumps
`timescale 1ns/1ps
module icache_mem_model import icache_pkg::*; (
  input  wire logic   ref_clk,  // Clock
  input  wire logic   reset,    // Sync reset
  input  mem_req_t    mem_out,  // Request from cache
  input  wire logic   slow,     // Insert wait states
  output logic        mem_ack,  // One word done
  output logic [31:0] mem_rdata // Read word
);
  logic [2:0] wait_cnt = 3'h0;
  initial mem_ack = 1'b0;
  // Idle data inverts so a stale word never passes for a fresh one
  always @(posedge ref_clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    wait_cnt  <= 3'h0;
    if (!reset && mem_out.req && !mem_ack && !(slow && wait_cnt < 3'h3)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem_out.addr ^ 32'h5a5a_0000;
    end else if (!reset && mem_out.req && !mem_ack) wait_cnt <= wait_cnt + 3'h1;
  end
endmodule : icache_mem_model

// ---- instruction_cache_with_fetch_buffer_tb_top.sv ----
// Bench: fetch hits, fill lengths, fetch buffer and enable control
`timescale 1ns/1ps
module instruction_cache_with_fetch_buffer_tb_top;
  import icache_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, fetch_req = 1'b0, slow = 1'b0, pready, pslverr;
  logic        fetch_ready, mem_ack, slverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, fetch_addr = 32'h0, prdata, mem_rdata, rd;
  fetch_rsp_t  fetch_rsp;
  mem_req_t    mem_out;
  int          err_count = 0, n_compared = 0, n_acks = 0, seed = 3642, buf_first = -1;
  int          q_line[$], q_first[$];
  int          n_base = 0;
  logic [27:0] buf_line = 28'h0, ln1, ln2, ln3;
  bit          en = 1'b1;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (mem_ack === 1'b1 && mem_out.req === 1'b1) n_acks++;
  instruction_cache_with_fetch_buffer instruction_cache_with_fetch_buffer_inst (
    .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_req(fetch_req), .fetch_addr(fetch_addr), .fetch_ready(fetch_ready),
    .fetch_rsp(fetch_rsp), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  icache_mem_model icache_mem_model_inst (.ref_clk(ref_clk), .reset(reset),
    .mem_out(mem_out), .slow(slow), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  // --------------------------------
  // Shared tasks
  // --------------------------------
  task give_verdict;
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge ref_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin err_count++; give_verdict; end
    rd = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Polls status until the busy bit drops
  task wait_idle;
    int k;
    for (k = 0; k < 5000; k++) begin
      apb(1'b0, {24'h0, OFF_STATUS}, 32'h0);
      if (rd[ST_BUSY_BIT] === 1'b0) break;
    end
    if (k == 5000) begin err_count++; give_verdict; end
  endtask : wait_idle
  task status_is(input logic e);
    apb(1'b0, {24'h0, OFF_STATUS}, 32'h0);
    check(rd[ST_ENABLED_BIT], e);
  endtask : status_is
  task forget;
    q_line.delete(); q_first.delete(); buf_first = -1;
  endtask : forget
  // Reference: hit if buffer or enabled cache holds the word, else a 2 or 4 word fill
  task fetch(input logic [27:0] ln, input logic [1:0] w);
    int k, f, n0;
    bit hit;
    f = (buf_line == ln) ? buf_first : -1;
    foreach (q_line[j]) if (en && q_line[j] == ln && w >= q_first[j]) f = q_first[j];
    hit = f >= 0 && w >= f;
    if (!hit) f = w & 2;
    if (!hit && en) begin q_line.push_back(ln); q_first.push_back(f); end
    buf_line = ln; buf_first = f; n0 = n_acks;
    @(posedge ref_clk);
    fetch_req <= 1'b1; fetch_addr <= {ln, w, 2'h0}; slow <= 1'($random(seed));
    @(negedge ref_clk);
    for (k = 0; k < 200 && fetch_ready !== 1'b1; k++) @(negedge ref_clk);
    if (k == 200) begin err_count++; give_verdict; end
    @(posedge ref_clk);
    fetch_req <= 1'b0;
    @(negedge ref_clk);
    check(fetch_rsp.done, 1);
    check(fetch_rsp.valid, (f == 0) ? 4'hf : 4'hc);
    check(fetch_rsp.words[w*32 +: 32], {ln, w, 2'h0} ^ 32'h5a5a_0000);
    check(n_acks - n0, hit ? 0 : 4 - f);
  endtask : fetch
  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    status_is(1'b1);
    apb(1'b0, 32'h40, 32'h0);
    check(rd, 0);
    check(slverr, 1'b1);
    ln1 = 28'($random(seed)); ln2 = 28'($random(seed)); ln3 = 28'($random(seed));
    fetch(ln1, 2'h0);
    fetch(ln1, 2'h2);
    fetch(ln2, 2'h2);
    fetch(ln2, 2'h3);
    fetch(ln2, 2'h0);
    fetch(ln1, 2'h1);
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h3);
    forget();
    fetch(ln1, 2'h1);
    apb(1'b1, {24'h0, OFF_CONFIG}, 32'h0001_0000);
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h6);
    forget(); en = 1'b0;
    status_is(1'b0);
    fetch(ln3, 2'h0);
    fetch(ln3, 2'h3);
    fetch(ln1, 2'h0);
    fetch(ln3, 2'h1);
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h15);
    en = 1'b1;
    status_is(1'b1);
    fetch(ln2, 2'h2);
    fetch(ln2, 2'h2);
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h2);
    status_is(1'b0);
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h1);
    status_is(1'b1);
    apb(1'b1, {24'h0, OFF_LOCK_ADDR}, {ln1, 4'h0});
    n_base = n_acks;
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h25);
    forget();
    for (int i = 0; i < KBYTES_FULL * 1024 / (WAYS * LINE_BYTES); i++) begin
      q_line.push_back(ln1 + 28'(i));
      q_first.push_back(0);
    end
    wait_idle();
    check(n_acks - n_base, KBYTES_FULL * 1024 / (WAYS * LINE_BYTES) * LINE_WORDS);
    check(rd[ST_LOCKED_BIT], 1'b1);
    check(rd[ST_ENABLED_BIT], 1'b1);
    fetch(ln1 + 28'h3, 2'h1);
    fetch(ln3, 2'h2);
    apb(1'b1, {24'h0, OFF_DUMP_ADDR}, 32'h0010_0000);
    n_base = n_acks;
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h4);
    wait_idle();
    check(n_acks - n_base, KBYTES_FULL * 1024 / LINE_BYTES * DUMP_SLOTS);
    apb(1'b1, {24'h0, OFF_COMMAND}, 32'h35);
    apb(1'b0, {24'h0, OFF_STATUS}, 32'h0);
    check(rd[ST_LOCKED_BIT], 1'b0);
    give_verdict;
  end
endmodule : instruction_cache_with_fetch_buffer_tb_top
